// >>> core/dar_core.sv
// request and activation logic of the four channel dma controller
`timescale 1ns/1ps
`default_nettype none
module dar_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [dar_pkg::ADR_W-1:0] wb_adr,
    input wire logic [dar_pkg::SEL_W-1:0] wb_sel,
    input wire logic [dar_pkg::DAT_W-1:0] wb_dat_i,
    output logic [dar_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack,
    // trigger sources
    input wire logic [dar_pkg::NUM_SRC-1:0] periph_irq,
    input wire logic [dar_pkg::NUM_PIN-1:0] ext_xfer_request_pin,
    // source flag handling
    output logic [dar_pkg::NUM_SRC-1:0] periph_flag_clr,
    output logic [dar_pkg::NUM_SRC-1:0] irq_to_cpu,
    // transfer engine handshake
    output dar_pkg::dar_unit_type unit_out,
    input wire logic unit_ack,
    input wire logic unit_periph_access
);
    localparam int NCH = dar_pkg::NUM_CH;
    localparam int NSRC = dar_pkg::NUM_SRC;

    // lowest set bit wins: {found, index}
    function automatic logic [2:0] first_one(input logic [NCH-1:0] v);
        first_one = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_one = {1'b1, 2'(i)};
            end
        end
    endfunction : first_one

    function automatic logic trig_ok(input logic full, input logic blk,
                                     input logic is_b, input dar_pkg::dar_trig_type t);
        logic per;
        logic ext;
        logic auto_req;
        // the spare trigger code enables nothing
        per = t == dar_pkg::TRIG_PERIPH;
        ext = t == dar_pkg::TRIG_EXT;
        auto_req = t == dar_pkg::TRIG_AUTO;
        if (full) begin
            // the pair runs as one channel on its A half
            trig_ok = is_b ? 1'b0 : (blk ? (per | ext) : (ext | auto_req));
        end else begin
            trig_ok = is_b ? (per | ext) : per;
        end
    endfunction : trig_ok

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : wmerge

    dar_pkg::dar_cfg_type cfg [NCH];
    dar_pkg::dar_cfg_type next_cfg [NCH];
    logic [dar_pkg::CNT_W-1:0] cnt [NCH];
    logic [dar_pkg::CNT_W-1:0] cnt_init [NCH];
    logic [dar_pkg::CNT_W-1:0] next_cnt [NCH];
    logic [dar_pkg::CNT_W-1:0] next_cnt_init [NCH];
    logic [NCH-1:0] pend;
    logic [NCH-1:0] next_pend;
    logic [NSRC-1:0] irq_q;
    logic [dar_pkg::NUM_PIN-1:0] pin_s1;
    logic [dar_pkg::NUM_PIN-1:0] pin_s2;
    logic [dar_pkg::NUM_PIN-1:0] pin_s3;
    dar_pkg::dar_state_type state;
    dar_pkg::dar_state_type next_state;
    logic [1:0] cur_ch;

    // bus decode
    wire wb_go = wb_cyc & wb_stb & ~wb_ack;
    wire wb_wr = wb_go & wb_we;
    wire [1:0] wb_ch = wb_adr[dar_pkg::ADR_BLK_LSB-1:dar_pkg::ADR_CH_LSB];
    wire [dar_pkg::ADR_W-1:0] wb_blk = {wb_adr[dar_pkg::ADR_W-1:dar_pkg::ADR_BLK_LSB],
                                        {dar_pkg::ADR_BLK_LSB{1'b0}}};
    wire cfg_hit = wb_blk == dar_pkg::ADR_CFG0;
    wire cnt_hit = wb_blk == dar_pkg::ADR_CNT0;
    wire stat_hit = wb_adr[dar_pkg::ADR_W-1:dar_pkg::ADR_CH_LSB]
                    == dar_pkg::ADR_STAT[dar_pkg::ADR_W-1:dar_pkg::ADR_CH_LSB];
    // merged write words for the addressed channel, cut to width where they land
    wire [31:0] wr_cfg_word = wmerge(32'(cfg[wb_ch]), wb_dat_i, wb_sel);
    wire [31:0] wr_cnt_word = wmerge(32'(cnt[wb_ch]), wb_dat_i, wb_sel);

    // synchronised pin and edge
    wire [dar_pkg::NUM_PIN-1:0] pin_fall = pin_s3 & ~pin_s2;
    wire [NSRC-1:0] irq_rise = periph_irq & ~irq_q;

    // per channel request terms
    logic [NCH-1:0] chan_ok;
    logic [NCH-1:0] req_vec;
    logic [NCH-1:0] is_auto;
    logic [NCH-1:0] is_level;
    logic [NCH-1:0] pend_set;
    logic [NSRC-1:0] dma_claim;
    logic [NSRC-1:0] grant_clr;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam int PA = (g / 2) * 2;
            localparam int PIN = g / 2;
            wire full = cfg[PA].full;
            // a source index past the last source never fires
            wire src_hit = (cfg[g].src < 4'(NSRC)) && irq_rise[cfg[g].src];
            // each channel decides on its own inputs plus the full and block bits of its pair's A channel
            assign chan_ok[g] = cfg[g].enable
                                & trig_ok(full, cfg[PA].block, g % 2 == 1, cfg[g].trig);
            assign is_auto[g] = chan_ok[g] & (cfg[g].trig == dar_pkg::TRIG_AUTO);
            assign is_level[g] = chan_ok[g] & (cfg[g].trig == dar_pkg::TRIG_EXT)
                                 & cfg[g].ext_level;
            assign pend_set[g] = chan_ok[g] & (
                ((cfg[g].trig == dar_pkg::TRIG_PERIPH) & src_hit)
                | ((cfg[g].trig == dar_pkg::TRIG_EXT) & ~cfg[g].ext_level
                   & pin_fall[PIN]));
            assign req_vec[g] = pend[g] | is_auto[g]
                                | (is_level[g] & ~pin_s2[PIN]);
        end
    endgenerate

    wire [2:0] pick = first_one(req_vec);
    wire grant = (state == dar_pkg::ST_IDLE) & pick[2];
    wire [1:0] gch = pick[1:0];
    wire cur_burst = is_auto[cur_ch] & cfg[cur_ch].burst;
    wire cur_last = cnt[cur_ch] == dar_pkg::CNT_LAST;
    wire unit_end = (state == dar_pkg::ST_XFER) & unit_ack;

    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            logic [NCH-1:0] users;
            logic [2:0] top;
            for (genvar c = 0; c < NCH; c++) begin : g_u
                assign users[c] = chan_ok[c] & (cfg[c].trig == dar_pkg::TRIG_PERIPH)
                                  & (cfg[c].src == 4'(g));
            end
            assign top = first_one(users);
            // only the dma consumes a source whose routing bit is set
            assign dma_claim[g] = |(users & {cfg[3].route, cfg[2].route,
                                             cfg[1].route, cfg[0].route});
            assign grant_clr[g] = (4'(g) >= dar_pkg::SRC_CLR_ON_GRANT) & grant & top[2]
                                  & (top[1:0] == gch) & cfg[gch].route;
        end
    endgenerate

    // converter and serial flags drop only when the unit touched their register
    wire acc_src = (cfg[cur_ch].trig == dar_pkg::TRIG_PERIPH) & cfg[cur_ch].route
                   & (cfg[cur_ch].src < dar_pkg::SRC_CLR_ON_GRANT);
    wire [NSRC-1:0] acc_clr = (unit_end & unit_periph_access & acc_src)
                              ? NSRC'(1) << cfg[cur_ch].src : '0;

    // register update
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_cfg[i] = cfg[i];
            next_cnt[i] = cnt[i];
            next_cnt_init[i] = cnt_init[i];
            next_pend[i] = pend[i];
            if (grant && gch == 2'(i)) begin
                next_pend[i] = 1'b0;
            end
            if (pend_set[i]) begin
                next_pend[i] = 1'b1;
            end
            if (!chan_ok[i]) begin
                next_pend[i] = 1'b0;
            end
            if (unit_end && cur_ch == 2'(i)) begin
                if (!cur_last) begin
                    next_cnt[i] = cnt[i] - 1'b1;
                end else if (cfg[i].repeat_on) begin
                    next_cnt[i] = cnt_init[i];
                end else begin
                    next_cnt[i] = cnt[i] - 1'b1;
                    next_cfg[i].enable = 1'b0;
                end
            end
            if (wb_wr && cfg_hit && wb_ch == 2'(i)) begin
                next_cfg[i] = dar_pkg::dar_cfg_type'(wr_cfg_word[dar_pkg::CFG_W-1:0]);
            end
            if (wb_wr && cnt_hit && wb_ch == 2'(i)) begin
                next_cnt[i] = wr_cnt_word[dar_pkg::CNT_W-1:0];
                next_cnt_init[i] = next_cnt[i];
            end
        end
    end

    // transfer sequencing
    always_comb begin
        next_state = state;
        case (state)
            dar_pkg::ST_IDLE: begin
                if (pick[2]) begin
                    next_state = dar_pkg::ST_XFER;
                end
            end
            dar_pkg::ST_XFER: begin
                if (unit_ack && !(cur_burst && !cur_last)) begin
                    next_state = dar_pkg::ST_GAP;
                end
            end
            dar_pkg::ST_GAP: begin
                // requests are looked at again, so a pin gone high ends it here
                next_state = dar_pkg::ST_IDLE;
            end
            default: begin
                next_state = dar_pkg::ST_IDLE;
            end
        endcase
    end

    wire [31:0] rd_cfg = 32'(cfg[wb_ch]);
    wire [31:0] rd_cnt = {cnt_init[wb_ch], cnt[wb_ch]};
    wire [31:0] rd_stat = 32'({pin_s2, chan_ok, pend});
    wire [31:0] rd_data = cfg_hit ? rd_cfg : cnt_hit ? rd_cnt : stat_hit ? rd_stat : '0;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= dar_pkg::CFG_RST;
                cnt[i] <= dar_pkg::CNT_RST;
                cnt_init[i] <= dar_pkg::CNT_RST;
            end
            pend <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= next_cfg[i];
                cnt[i] <= next_cnt[i];
                cnt_init[i] <= next_cnt_init[i];
            end
            pend <= next_pend;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
            irq_q <= '0;
        end else begin
            pin_s1 <= ext_xfer_request_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            irq_q <= periph_irq;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= dar_pkg::ST_IDLE;
            cur_ch <= 2'h0;
            unit_out <= '0;
        end else begin
            state <= next_state;
            if (grant) begin
                cur_ch <= gch;
                unit_out.chan <= gch;
                unit_out.word_size <= cfg[gch].word_size;
                unit_out.lock <= is_auto[gch] & cfg[gch].burst;
            end
            unit_out.req <= next_state == dar_pkg::ST_XFER;
            if (next_state != dar_pkg::ST_XFER) begin
                unit_out.lock <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_flag_clr <= '0;
            irq_to_cpu <= '0;
            wb_ack <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            periph_flag_clr <= grant_clr | acc_clr;
            irq_to_cpu <= periph_irq & ~dma_claim;
            wb_ack <= wb_go;
            wb_dat_o <= wb_go ? rd_data : '0;
        end
    end
endmodule : dar_core
`default_nettype wire

// >>> core/dar_pkg.sv
// constants and types for the dma activation request logic
package dar_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_SRC = 11;
    localparam int NUM_PIN = 2;
    localparam int CNT_W = 16;
    localparam int CFG_W = 14;
    localparam int DAT_W = 32;
    localparam int ADR_W = 8;
    localparam int SEL_W = 4;

    // byte addresses of the register blocks
    localparam logic [ADR_W-1:0] ADR_CFG0 = 8'h00;
    localparam logic [ADR_W-1:0] ADR_CNT0 = 8'h10;
    localparam logic [ADR_W-1:0] ADR_STAT = 8'h20;
    localparam int ADR_CH_LSB = 2;
    localparam int ADR_BLK_LSB = 4;

    // trigger source indices on the periph_irq vector
    localparam int SRC_CONV_END = 0;
    localparam int SRC_SER0_TX = 1;
    localparam int SRC_SER0_RX = 2;
    localparam int SRC_SER1_TX = 3;
    localparam int SRC_SER1_RX = 4;
    localparam int SRC_TIMER0 = 5;
    // sources below this index drop their flag only on a register access
    localparam logic [3:0] SRC_CLR_ON_GRANT = 4'h5;

    localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    typedef enum logic [1:0] {
        TRIG_PERIPH,
        TRIG_EXT,
        TRIG_AUTO
    } dar_trig_type;

    // per channel configuration word, bit 0 is enable
    typedef struct packed {
        logic word_size;
        logic block;
        logic full;
        logic repeat_on;
        logic burst;
        logic ext_level;
        logic [3:0] src;
        dar_trig_type trig;
        logic route;
        logic enable;
    } dar_cfg_type;

    localparam dar_cfg_type CFG_RST = '0;

    // one unit transfer request towards the transfer engine
    typedef struct packed {
        logic req;
        logic [1:0] chan;
        logic lock;
        logic word_size;
    } dar_unit_type;

    typedef enum {
        ST_IDLE,
        ST_XFER,
        ST_GAP
    } dar_state_type;
endpackage : dar_pkg

// >>> verif/dar_core_bench.sv
// self-checking bench for the dma activation request logic
`timescale 1ns/1ps
`default_nettype none
bind dar_core dar_core_props u_dar_core_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
    .periph_irq(periph_irq), .periph_flag_clr(periph_flag_clr), .irq_to_cpu(irq_to_cpu),
    .unit_out(unit_out), .unit_ack(unit_ack), .unit_periph_access(unit_periph_access));
module dar_core_bench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack;
    logic [10:0] periph_irq = 11'h000;
    logic [1:0] ext_xfer_request_pin;
    logic [10:0] periph_flag_clr;
    logic [10:0] irq_to_cpu;
    dar_pkg::dar_unit_type unit_out;
    logic unit_ack = 1'b0;
    logic unit_periph_access = 1'b0;
    logic fire = 1'b0;
    logic hold = 1'b0;
    logic [31:0] rd;
    int n_fail = 0;
    int check_count = 0;
    int n_clr = 0;
    int seed = 22596;
    int cnt_model [4];
    logic word_model [4];
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (|periph_flag_clr) n_clr <= n_clr + 1;
    dar_core u_dar_core (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .periph_irq(periph_irq),
        .ext_xfer_request_pin(ext_xfer_request_pin), .periph_flag_clr(periph_flag_clr),
        .irq_to_cpu(irq_to_cpu), .unit_out(unit_out), .unit_ack(unit_ack),
        .unit_periph_access(unit_periph_access));
    dar_req_pin_model u_dar_req_pin_model (.ref_clk(ref_clk), .fire(fire), .hold(hold),
        .pin(ext_xfer_request_pin));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        t = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge ref_clk);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        check("bus ack", 1'b1, wb_ack);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0000_0000);
        check(what, exp, rd);
    endtask : rd_chk
    task automatic set_ch(input int ch, input logic [31:0] cfg, input int cnt);
        cnt_model[ch] = cnt;
        word_model[ch] = cfg[13];
        bus(1'b1, 8'(8'h10 + 4 * ch), 32'(cnt));
        bus(1'b1, 8'(4 * ch), cfg);
    endtask : set_ch
    // lk of 2 skips the lock check on a last unit
    task automatic unit(input logic [1:0] ch, input int lk, input logic acc);
        int t;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (unit_out.req !== 1'b1 && t < 50);
        check("unit chan", ch, unit_out.chan);
        if (lk < 2) check("unit lock", lk, unit_out.lock);
        check("unit word", word_model[ch], unit_out.word_size);
        unit_ack <= 1'b1;
        unit_periph_access <= acc;
        @(posedge ref_clk);
        unit_ack <= 1'b0;
        cnt_model[ch] = cnt_model[ch] - 1;
    endtask : unit
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        #2000000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd_chk("cfg0 reset", 8'h00, 32'h0000_0000);
        bus(1'b1, 8'hfc, 32'hffff_ffff);
        rd_chk("unmapped", 8'hfc, 32'h0000_0000);
        // one timer flag shared by two channels
        set_ch(0, 32'h0000_0053, 2);
        set_ch(2, 32'h0000_0053, 2);
        periph_irq[5] <= 1'b1;
        unit(2'd0, 0, 1'b0);
        unit(2'd2, 0, 1'b0);
        repeat (3) @(posedge ref_clk);
        check("timer clears", 1, n_clr);
        rd_chk("count0", 8'h10, {16'h0002, 16'(cnt_model[0])});
        periph_irq <= 11'h000;
        for (int r = 0; r < 2; r++) begin
            n_clr = 0;
            set_ch(2, 32'h0000_0001 | (32'(r) << 1), 1);
            periph_irq[0] <= 1'b1;
            unit(2'd2, 0, 1'b1);
            repeat (3) @(posedge ref_clk);
            check("conv clears", r, n_clr);
            check("conv to cpu", 1, irq_to_cpu[0]);
            rd_chk("cfg2 end", 8'h08, 32'(r) << 1);
            periph_irq <= 11'h000;
        end
        // next fall only after the unit is done
        set_ch(1, 32'h0000_0005, 2);
        repeat (2) begin
            fire <= 1'b1;
            @(posedge ref_clk);
            fire <= 1'b0;
            unit(2'd1, 0, 1'b0);
        end
        rd_chk("cfg1 end", 8'h04, 32'h0000_0004);
        // level sensing: units while the pin stays low, none once it is high again
        set_ch(1, 32'h0000_2105, 5);
        hold <= 1'b1;
        unit(2'd1, 0, 1'b0);
        do @(posedge ref_clk); while (unit_out.req !== 1'b1);
        hold <= 1'b0;
        repeat (3) @(posedge ref_clk);
        unit(2'd1, 0, 1'b0);
        repeat (8) @(posedge ref_clk);
        check("level stop", 0, unit_out.req);
        rd_chk("count1", 8'h14, {16'h0005, 16'(cnt_model[1])});
        for (int b = 0; b < 2; b++) begin
            set_ch(0, 32'h0000_0809 | (32'(b) << 9), 3);
            for (int i = 0; i < 3; i++) unit(2'd0, (i < 2) ? b : 2, 1'b0);
            rd_chk("cfg0 end", 8'h00, 32'h0000_0808 | (32'(b) << 9));
        end
        // repeat reloads the count and stays enabled; routing zero keeps the flag
        n_clr = 0;
        set_ch(2, 32'h0000_0451, 1);
        periph_irq[5] <= 1'b1;
        unit(2'd2, 0, 1'b0);
        repeat (3) @(posedge ref_clk);
        check("timer kept", 0, n_clr);
        rd_chk("cfg2 repeat", 8'h08, 32'h0000_0451);
        rd_chk("count2 repeat", 8'h18, 32'h0001_0001);
        repeat (4) begin
            periph_irq <= 11'($random(seed));
            repeat (3) @(posedge ref_clk);
            check("cpu irq", periph_irq, irq_to_cpu);
        end
        conclude();
    end
endmodule : dar_core_bench
`default_nettype wire

// >>> verif/dar_core_props.sv
// assertion checker for the dma activation request logic ports
`timescale 1ns/1ps
`default_nettype none
module dar_core_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register bus
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic [dar_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack,
    // sources and flags
    input wire logic [dar_pkg::NUM_SRC-1:0] periph_irq,
    input wire logic [dar_pkg::NUM_SRC-1:0] periph_flag_clr,
    input wire logic [dar_pkg::NUM_SRC-1:0] irq_to_cpu,
    // transfer link
    input wire dar_pkg::dar_unit_type unit_out,
    input wire logic unit_ack,
    input wire logic unit_periph_access
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ack_resp_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("bus request not answered next cycle");
    ack_once_a: assert property (wb_ack |=> !wb_ack)
        else $error("bus ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack |-> wb_dat_o == '0)
        else $error("read data outside ack cycle");
    req_hold_a: assert property (unit_out.req && !unit_ack |=> unit_out.req)
        else $error("unit request dropped before ack");
    chan_stable_a: assert property (unit_out.req && !unit_ack |=> $stable(unit_out.chan))
        else $error("unit channel changed while pending");
    steal_gap_a: assert property (unit_out.req && unit_ack && !unit_out.lock
        |=> !unit_out.req ##1 !unit_out.req)
        else $error("bus not released after unit");
    lock_req_a: assert property (unit_out.lock |-> unit_out.req)
        else $error("bus lock without unit request");
    access_clear_a: assert property (|periph_flag_clr[4:0]
        |-> $past(unit_ack && unit_periph_access))
        else $error("source flag cleared without register access");
    cpu_route_a: assert property ((irq_to_cpu & ~$past(periph_irq)) == '0)
        else $error("processor irq without source flag");
endmodule : dar_core_props
`default_nettype wire

// >>> verif/dar_req_pin_model.sv
// model of the external requester on the request pins
`timescale 1ns/1ps
`default_nettype none
module dar_req_pin_model (
    // clock and command
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic hold,
    // request pins, active low
    output logic [1:0] pin
);
    int low_left = 0;
    // low for three cycles so the synchroniser sees a clean fall
    always @(posedge ref_clk) begin
        if (fire) low_left <= 3;
        else if (low_left > 0) low_left <= low_left - 1;
    end
    // pin 1 has no requester and rests at its pull-up level; hold keeps pin 0 low
    assign pin = {1'b1, low_left == 0 && !hold};
endmodule : dar_req_pin_model
`default_nettype wire
